// *** self_test_defs.vh ***
/*
  Constants for the buffer memory self-test engine: register offsets,
  control field positions, reset values and memory geometry.
  Assumes inclusion by bare name from the design file.
*/
`ifndef SELF_TEST_DEFS_VH
`define SELF_TEST_DEFS_VH

// ==========================================================
// Register byte addresses on APB
`define OFF_CONTROL 12'h000
`define OFF_SEED 12'h004
`define OFF_SUM_LOW 12'h008
`define OFF_SUM_HIGH 12'h00c
`define OFF_MEM_ADDR 12'h010
`define OFF_MEM_DATA 12'h014

// ==========================================================
// Control register fields
`define CTL_BUSY 0
`define CTL_TME 1
`define CTL_MODE_LO 2
`define CTL_MODE_HI 3
`define CTL_PSEL 4
`define CTL_SHIFT_LO 5
`define CTL_SHIFT_HI 7

// ==========================================================
// Fill mode codes
`define MODE_RANDOM 2'h0
`define MODE_ADDRESS 2'h1
`define MODE_SHIFT 2'h2

// ==========================================================
// Reset values and geometry
`define CONTROL_RESET 8'h00
`define SEED_RESET 8'h00
`define SUM_RESET 16'h0000
`define MEM_AW 13
`define MEM_LAST 13'h1fff
`define LFSR_TAPS 8'hb8
`define LFSR_ZERO_FIX 8'h01
`define REG_ZERO 24'h000000
`define WORD_ZERO 32'h00000000
`define BYTE_ZERO 8'h00
`define ADDR_ZERO 13'h0000
`define ADDR_STEP 13'h0001
`define ADDR_PAD 19'h00000
`define BYTE_HI 7
`define BYTE_LO 0
`define MEM_MSB 12

`endif

// *** memory_self_test.v ***
/*
  Buffer memory self-test engine with its 8 Kbyte buffer memory and an
  APB register slave. Assumes a single 20 MHz clock and that software
  idles the DMA, receive and transmit paths before starting a test.
*/
`timescale 1ns/1ps
`default_nettype none
`include "self_test_defs.vh"

// How it works
// - A started test writes all 8192 byte locations of the buffer.
// - The fill uses one memory write port and the DMA port uses the other.
// - Pattern comes from fill_seed, directly or as the random generator start.
// - Pattern shift mode rotates the seed left by shift_amount after each write.
// - Random, address and reserved modes ignore shift_amount.
// - Port select swaps the DMA and self-test memory write ports; read ports stay fixed.
// - Fill mode 00 random, 01 address, 10 pattern shift, 11 reserved.
// - test_mode_enable bit 1 enables test mode when set.
// - test_start_busy reads 1 while running, self-clears when finished.
// - A 16-bit checksum of the memory is readable as high and low bytes.
module memory_self_test (
  input wire pclk,
  input wire presetn,
  input wire psel,
  input wire penable,
  input wire pwrite,
  input wire [11:0] paddr,
  input wire [31:0] pwdata,
  output reg [31:0] prdata,
  output wire pready,
  output wire pslverr,
  input wire dma_we,
  input wire [12:0] dma_addr,
  input wire [7:0] dma_wdata,
  output reg [7:0] dma_rdata,
  output wire test_active
);

  // ==========================================================
  // States
  localparam [3:0] ST_IDLE = 4'b0001;
  localparam [3:0] ST_FILL = 4'b0010;
  localparam [3:0] ST_SUM = 4'b0100;
  localparam [3:0] ST_LAST = 4'b1000;

  reg [7:0] control_q;
  reg [7:0] seed_q;
  reg [15:0] sum_q;
  reg [3:0] state_q;
  reg [3:0] state_d;
  reg [12:0] addr_q;
  reg [7:0] pattern_q;
  reg [12:0] sw_addr_q;
  reg rd_valid_q;
  reg [31:0] read_word;
  reg [7:0] mem [0:8191];
  reg [7:0] port_a_rdata;
  reg [7:0] port_b_rdata;

  wire [1:0] fill_mode = control_q[`CTL_MODE_HI:`CTL_MODE_LO];
  wire [2:0] shift_amount = control_q[`CTL_SHIFT_HI:`CTL_SHIFT_LO];
  wire port_swap = control_q[`CTL_PSEL];
  wire test_mode_enable = control_q[`CTL_TME];
  wire busy = control_q[`CTL_BUSY];

  // ==========================================================
  // APB decode
  wire wr_en = psel & penable & pwrite;
  wire rd_en = psel & penable & ~pwrite;
  wire hit_ctl = (paddr == `OFF_CONTROL);
  wire hit_seed = (paddr == `OFF_SEED);
  wire hit_lo = (paddr == `OFF_SUM_LOW);
  wire hit_hi = (paddr == `OFF_SUM_HIGH);
  wire hit_ma = (paddr == `OFF_MEM_ADDR);
  wire hit_md = (paddr == `OFF_MEM_DATA);
  wire mapped = hit_ctl | hit_seed | hit_lo | hit_hi | hit_ma | hit_md;
  // Memory data reads need one wait state for the synchronous array
  wire md_wait = rd_en & hit_md & ~rd_valid_q;
  assign pready = ~md_wait;
  assign pslverr = psel & penable & ~mapped;
  assign test_active = busy;

  // ==========================================================
  // Fill data generation
  reg [7:0] fill_data;
  always @* begin
    case (fill_mode)
      `MODE_RANDOM: begin
        fill_data = pattern_q;
      end
      `MODE_ADDRESS: begin
        fill_data = addr_q[`BYTE_HI:`BYTE_LO];
      end
      `MODE_SHIFT: begin
        fill_data = pattern_q;
      end
      default: begin
        // Reserved code: the seed is written unchanged everywhere
        fill_data = pattern_q;
      end
    endcase
  end

  // Rotation is the only use of shift_amount, gated by mode
  wire [15:0] doubled = {pattern_q, pattern_q} << shift_amount;
  reg [7:0] rotated;
  always @* begin
    rotated = pattern_q;
    if (fill_mode == `MODE_SHIFT) begin
      rotated = doubled[15:8];
    end
  end

  // Galois LFSR; all-zero seed would lock up, so it is forced to one
  wire [7:0] lfsr_next = pattern_q[0] ? ((pattern_q >> 1) ^ `LFSR_TAPS) : (pattern_q >> 1);

  // ==========================================================
  // Memory ports: both A and B can write; A reads at rd_addr, B at dma_addr.
  // Normally the self-test writes through A and the DMA through B; swap exchanges only the writes.
  wire memory_self_test_write = (state_q == ST_FILL);
  wire we_a = port_swap ? dma_we : memory_self_test_write;
  wire [12:0] addr_a = port_swap ? dma_addr : addr_q;
  wire [7:0] data_a = port_swap ? dma_wdata : fill_data;
  wire memory_self_test_we_b = port_swap & memory_self_test_write;
  wire we_b = port_swap ? memory_self_test_we_b : dma_we;
  wire [12:0] addr_b = port_swap ? addr_q : dma_addr;
  wire [7:0] data_b = port_swap ? fill_data : dma_wdata;
  wire [12:0] rd_addr = busy ? addr_q : sw_addr_q;

  always @(posedge pclk) begin
    if (we_a) begin
      mem[addr_a] <= data_a;
    end
    if (we_b) begin
      mem[addr_b] <= data_b;
    end
    port_a_rdata <= mem[rd_addr];
    port_b_rdata <= mem[dma_addr];
  end

  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      dma_rdata <= 8'h00;
    end else begin
      dma_rdata <= port_b_rdata;
    end
  end

  // ==========================================================
  // Engine and registers
  wire start = wr_en & hit_ctl & pwdata[`CTL_BUSY] & pwdata[`CTL_TME] & ~busy;
  wire [7:0] seed_start = (pwdata[`CTL_MODE_HI:`CTL_MODE_LO] == `MODE_RANDOM && seed_q == `BYTE_ZERO) ?
                          `LFSR_ZERO_FIX : seed_q;

  // ==========================================================
  // Sequencer: fill every byte, read every byte back, then one drain cycle
  // Drain is needed because the array answers one clock late
  always @* begin
    state_d = state_q;
    case (state_q)
      ST_IDLE: begin
        if (start) begin
          state_d = ST_FILL;
        end
      end
      ST_FILL: begin
        if (addr_q == `MEM_LAST) begin
          state_d = ST_SUM;
        end
      end
      ST_SUM: begin
        if (addr_q == `MEM_LAST) begin
          state_d = ST_LAST;
        end
      end
      ST_LAST: begin
        state_d = ST_IDLE;
      end
      default: begin
        state_d = ST_IDLE;
      end
    endcase
  end

  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      state_q <= ST_IDLE;
    end else begin
      state_q <= state_d;
    end
  end

  // One counter walks the array twice
  // It wraps from the last byte to zero between fill and read-back
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      addr_q <= `ADDR_ZERO;
    end else if ((state_q == ST_FILL) || (state_q == ST_SUM)) begin
      addr_q <= addr_q + `ADDR_STEP;
    end else begin
      addr_q <= `ADDR_ZERO;
    end
  end

  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pattern_q <= `BYTE_ZERO;
    end else if (start) begin
      pattern_q <= seed_start;
    end else if (state_q == ST_FILL) begin
      if (fill_mode == `MODE_RANDOM) begin
        pattern_q <= lfsr_next;
      end else begin
        pattern_q <= rotated;
      end
    end
  end

  // ==========================================================
  // Checksum: the byte arriving now sits just below addr_q
  // An odd addr_q means an even byte, which weighs as the high half
  wire sum_take = ((state_q == ST_SUM) && (addr_q != `ADDR_ZERO)) || (state_q == ST_LAST);
  wire [15:0] sum_addend = addr_q[0] ? {port_a_rdata, `BYTE_ZERO} : {`BYTE_ZERO, port_a_rdata};

  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      sum_q <= `SUM_RESET;
    end else if (start) begin
      sum_q <= `SUM_RESET;
    end else if (sum_take) begin
      sum_q <= sum_q + sum_addend;
    end
  end

  // ==========================================================
  // Registers: control and seed are frozen while a test runs
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      control_q <= `CONTROL_RESET;
    end else if (wr_en & hit_ctl & ~busy) begin
      control_q <= {pwdata[`CTL_SHIFT_HI:`CTL_TME], start};
    end else if (state_q == ST_LAST) begin
      control_q[`CTL_BUSY] <= 1'b0;
    end
  end

  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      seed_q <= `SEED_RESET;
    end else if (wr_en & hit_seed & ~busy) begin
      seed_q <= pwdata[`BYTE_HI:`BYTE_LO];
    end
  end

  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      sw_addr_q <= `ADDR_ZERO;
    end else if (wr_en & hit_ma) begin
      sw_addr_q <= pwdata[`MEM_MSB:`BYTE_LO];
    end
  end

  // The wait flag lasts one cycle, so the second access cycle completes
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      rd_valid_q <= 1'b0;
    end else begin
      rd_valid_q <= md_wait;
    end
  end

  // ==========================================================
  // Read mux
  always @* begin
    read_word = `WORD_ZERO;
    if (hit_ctl) begin
      read_word = {`REG_ZERO, control_q};
    end else if (hit_seed) begin
      read_word = {`REG_ZERO, seed_q};
    end else if (hit_lo) begin
      read_word = {`REG_ZERO, sum_q[7:0]};
    end else if (hit_hi) begin
      read_word = {`REG_ZERO, sum_q[15:8]};
    end else if (hit_ma) begin
      read_word = {`ADDR_PAD, sw_addr_q};
    end else if (hit_md) begin
      read_word = {`REG_ZERO, port_a_rdata};
    end
  end

  // Read data is a register: it follows the mux through setup and wait cycles
  // and holds still in the cycle that completes, one clock behind the mux
  wire rd_load = psel & ~pwrite & ~(penable & pready);

  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata <= `WORD_ZERO;
    end else if (rd_load) begin
      prdata <= read_word;
    end
  end

endmodule
`default_nettype wire

// *** self_test_properties.sv ***
/* Checker for the self-test block's APB and busy ports.
   Bound to memory_self_test from the testbench file. */
`timescale 1ns/1ps
`default_nettype none
`include "self_test_defs.vh"
module self_test_properties (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [31:0] prdata,
  input wire logic pready,
  input wire logic pslverr,
  input wire logic test_active
);
  // ===
  // Helper logic
  logic [15:0] run_q;
  logic acc, wctl, mapd;
  assign acc = psel && penable;
  assign wctl = acc && pwrite && pready && paddr == `OFF_CONTROL;
  assign mapd = paddr inside {`OFF_CONTROL, `OFF_SEED, `OFF_SUM_LOW, `OFF_SUM_HIGH, `OFF_MEM_ADDR, `OFF_MEM_DATA};
  // Free-running length of the current test, cleared when idle
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) run_q <= 16'h0000;
    else run_q <= test_active ? run_q + 16'h0001 : 16'h0000;
  end
  default clocking @(posedge pclk); endclocking
  default disable iff (!presetn);
  // ===
  // Properties
  a_start_sets_busy: assert property (wctl && pwdata[1:0] == 2'b11 && !test_active |=> test_active)
    else $error("start did not set busy");
  a_start_needs_enable: assert property (wctl && !pwdata[1] && !test_active |=> !test_active)
    else $error("start without enable");
  a_busy_write_ignored: assert property (wctl && test_active |=> test_active)
    else $error("busy dropped by write");
  a_busy_readback: assert property (acc && !pwrite && paddr == `OFF_CONTROL |-> prdata[0] == $past(test_active))
    else $error("busy bit mismatch");
  a_full_fill_length: assert property ($fell(test_active) |-> $past(run_q) >= 16'd16383)
    else $error("test ended too early");
  a_run_bounded: assert property (run_q <= 16'd16400)
    else $error("test never ended");
  a_unmapped_error: assert property (acc && !mapd |-> pslverr && (pwrite || prdata == 32'h0))
    else $error("unmapped access not refused");
  a_mem_wait_state: assert property (acc && $rose(penable) && !pwrite && paddr == `OFF_MEM_DATA |-> !pready ##1 pready)
    else $error("memory read wait state wrong");
  c_run: cover property ($fell(test_active));
  c_err: cover property (pslverr);
  c_mem: cover property (acc && !pready);
endmodule
`default_nettype wire

// *** testbench.sv ***
/* Self-checking bench: APB tasks run every fill mode and check sums.
   Assumes memory_self_test and its defs header compiled first. */
`timescale 1ns/1ps
`default_nettype none
`include "self_test_defs.vh"
module testbench;
  logic pclk, presetn, psel, penable, pwrite, dma_we;
  logic [11:0] paddr;
  logic [31:0] pwdata;
  logic [12:0] dma_addr;
  logic [7:0] dma_wdata;
  wire [31:0] prdata;
  wire [7:0] dma_rdata;
  wire pready, pslverr, test_active;
  logic err_seen;
  int num_errors = 0;
  int num_checks = 0;
  memory_self_test dut (.pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata, .pready,
    .pslverr, .dma_we, .dma_addr, .dma_wdata, .dma_rdata, .test_active);
  initial begin
    pclk = 0;
    forever #25 pclk = ~pclk;
  end
  // ===
  // Tasks
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    num_checks++;
    if (got !== exp) begin
      num_errors++;
      $display("CHECK FAILED at %0t: got %h want %h", $time, got, exp);
    end
  endtask
  // Holds the request until pready is seen high at an edge
  task automatic xfer(input logic w, input logic [11:0] a, input logic [31:0] d, output logic [31:0] r);
    @(posedge pclk);
    psel <= 1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1;
    do @(posedge pclk); while (pready !== 1'b1);
    r = prdata;
    err_seen = pslverr;
    psel <= 0;
    penable <= 0;
  endtask
  task automatic rdchk(input logic [11:0] a, input logic [31:0] exp);
    logic [31:0] r;
    xfer(0, a, 0, r);
    chk(r, exp);
  endtask
  task automatic tally_and_finish;
    $display("checks %0d errors %0d", num_checks, num_errors);
    if (num_errors == 0 && num_checks > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask
  // Byte-pair sum and last byte of a full fill, worked out from the modes
  function automatic logic [23:0] exp_fill(input logic [1:0] m, input logic [7:0] s, input logic [2:0] sh);
    logic [15:0] acc;
    logic [7:0] b, v;
    acc = 16'h0000;
    b = s;
    v = s;
    for (int i = 0; i < 8192; i++) begin
      v = (m == `MODE_ADDRESS) ? i[7:0] : b;
      acc = acc + (i[0] ? {8'h00, v} : {v, 8'h00});
      if (m == `MODE_SHIFT) b = (b << sh) | (b >> (4'h8 - {1'b0, sh}));
      else if (m == `MODE_RANDOM) b = b[0] ? (b >> 1) ^ `LFSR_TAPS : b >> 1;
    end
    return {v, acc};
  endfunction
  task automatic run(input logic [1:0] m, input logic [7:0] s, input logic [2:0] sh, input logic p);
    logic [31:0] r;
    logic [7:0] ctl;
    logic [23:0] ex;
    int n;
    ctl = {sh, p, m, 2'b11};
    ex = exp_fill(m, s, sh);
    xfer(1, `OFF_SEED, {24'h0, s}, r);
    xfer(1, `OFF_CONTROL, {24'h0, ctl}, r);
    xfer(1, `OFF_CONTROL, 32'h0, r);
    rdchk(`OFF_CONTROL, {24'h0, ctl});
    n = 0;
    do begin
      xfer(0, `OFF_CONTROL, 0, r);
      n++;
    end while (r[0] && n < 20000);
    chk(r, {24'h0, ctl & 8'hfe});
    rdchk(`OFF_SUM_LOW, {24'h0, ex[7:0]});
    rdchk(`OFF_SUM_HIGH, {24'h0, ex[15:8]});
    xfer(1, `OFF_MEM_ADDR, {19'h0, `MEM_LAST}, r);
    rdchk(`OFF_MEM_DATA, {24'h0, ex[23:16]});
    dma_addr <= `MEM_LAST;
    repeat (3) @(posedge pclk);
    chk({24'h0, dma_rdata}, {24'h0, ex[23:16]});
    $display("Test mode %0d done", m);
  endtask
  // ===
  // Main sequence
  initial begin
    logic [31:0] r;
    presetn = 0;
    {psel, penable, pwrite, dma_we} = 4'h0;
    paddr = 12'h000;
    pwdata = 32'h0;
    dma_addr = 13'h0000;
    dma_wdata = 8'h00;
    repeat (3) @(posedge pclk);
    presetn <= 1;
    rdchk(`OFF_CONTROL, 32'h0);
    rdchk(`OFF_SUM_HIGH, 32'h0);
    xfer(0, 12'h020, 0, r);
    chk({31'h0, err_seen}, 32'h1);
    chk(r, 32'h0);
    xfer(1, `OFF_CONTROL, 32'h1, r);
    rdchk(`OFF_CONTROL, 32'h0);
    $display("Test registers done");
    run(`MODE_ADDRESS, 8'h5a, 3'h3, 0);
    run(`MODE_SHIFT, 8'h81, 3'h3, 1);
    run(`MODE_RANDOM, 8'h5a, 3'h5, 0);
    run(2'h3, 8'h3c, 3'h7, 0);
    dma_we <= 1;
    dma_addr <= 13'h0005;
    dma_wdata <= 8'ha5;
    @(posedge pclk);
    dma_we <= 0;
    xfer(1, `OFF_MEM_ADDR, 32'h5, r);
    rdchk(`OFF_MEM_DATA, 32'ha5);
    $display("Test dma port done");
    tally_and_finish();
  end
  initial begin
    #(90000 * 50);
    num_errors++;
    tally_and_finish();
  end
endmodule
bind memory_self_test self_test_properties u_props (.pclk, .presetn, .psel, .penable, .pwrite, .paddr,
  .pwdata, .prdata, .pready, .pslverr, .test_active);
`default_nettype wire
